/* File: pmsw_status.sv */
// power status and wake control register block with apb slave
`timescale 1ns/1ps
`include "pmsw_regs.svh"

// What this block does
// R1 - status resets zero, kept across standby wake
// R2 - half-word and word accesses both accepted
// R3 - low-driver field reads 11 after entry
// R4 - writing 11 clears low-driver field
// R5 - bit 17 shows high-driver switch ready
// R6 - bit 16 shows high-driver ready
// R7 - bit 14 shows voltage select ready
// R8 - enabled wake pin rising edge wakes standby
// R9 - pull-down applied while wake pin enabled
// R10 - enabling with pin high raises wake event
// R11 - bit 2 shows low-voltage detector output
// R12 - detector flag frozen during standby
// R13 - standby flag set after standby
// R14 - standby flag cleared by reset or strobe
// R15 - wakeup flag set by pin or alarm
// R16 - wakeup flag cleared by reset or strobe
// R17 - software writes reserved bits as zero
// R18 - clear strobes read zero, zero writes ignored
// R19 - software sets switch only when ready
// R20 - read-only flags ignore writes, synchronised
module pmsw_status (
  input wire logic mclk, // bus clock, 100 MHz
  input wire logic rst, // power-on/power-down reset, sync, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic wake_pin, // wake pin level, asynchronous
  input wire logic rtc_alarm, // alarm level, asynchronous
  input wire logic standby_active, // high while in standby
  input wire logic deep_sleep_low_driver, // high in low-driver sleep
  input wire logic high_driver_switch_ready_in, // switch ready
  input wire logic high_driver_ready_in, // high-driver ready
  input wire logic regulator_voltage_select_ready_in, // vsel ready
  input wire logic low_voltage_detector, // detector output
  output logic wake_pin_pull_down, // pull-down on wake pin
  output logic standby_wake // one-cycle request to leave standby
);

  // ************************************************************
  // synchronised inputs
  // ************************************************************
  logic [7:0] raw_in; // asynchronous sources grouped
  logic [7:0] sync_in; // same, two flops later
  logic wake_s; // wake pin
  logic rtc_s; // alarm
  logic stby_s; // standby state
  logic ldr_s; // low-driver deep-sleep state
  logic hdsr_s; // switch ready
  logic hdr_s; // high-driver ready
  logic vsr_s; // voltage select ready
  logic lvd_s; // detector

  assign raw_in = {wake_pin, rtc_alarm, standby_active,
                   deep_sleep_low_driver, high_driver_switch_ready_in,
                   high_driver_ready_in,
                   regulator_voltage_select_ready_in,
                   low_voltage_detector};

  // every status source crosses here before any logic reads it
  pmsw_sync #(.WIDTH(8)) u_sync ( // R20
    .mclk(mclk),
    .rst(rst),
    .d(raw_in),
    .q(sync_in)
  );

  assign {wake_s, rtc_s, stby_s, ldr_s, hdsr_s, hdr_s, vsr_s,
          lvd_s} = sync_in;

  // ************************************************************
  // state registers
  // ************************************************************
  logic wake_d_ff; // wake pin one cycle ago
  logic rtc_d_ff; // alarm one cycle ago
  logic ldr_d_ff; // low-driver state one cycle ago
  logic wake_en_ff; // wake pin enable, bit 8
  logic wuf_ff; // wakeup flag
  logic standby_flag_ff; // standby flag
  logic low_voltage_flag_ff; // detector flag
  pmsw_pkg::pmsw_ldr_type ldr_ff; // low-driver ready field
  logic wake_req_ff; // standby wake pulse
  logic [31:0] rdata_ff; // read data
  logic slverr_ff; // error answer

  // ************************************************************
  // apb decode
  // ************************************************************
  function automatic pmsw_pkg::pmsw_sel_type decode(
    input logic [11:0] addr
  );
    if (addr == `PMSW_CTL_OFS) begin
      decode = pmsw_pkg::pmsw_sel_ctl;
    end else if (addr == `PMSW_STAT_OFS) begin
      decode = pmsw_pkg::pmsw_sel_stat;
    end else begin
      decode = pmsw_pkg::pmsw_sel_none;
    end
  endfunction : decode

  pmsw_pkg::pmsw_sel_type sel; // register hit
  wire setup_ph = psel & ~penable; // first cycle of a transfer
  wire access_ph = psel & penable; // completing cycle
  wire hit_ctl = (sel == pmsw_pkg::pmsw_sel_ctl);
  wire hit_stat = (sel == pmsw_pkg::pmsw_sel_stat);
  wire wr_ctl = access_ph & pwrite & hit_ctl;
  wire wr_stat = access_ph & pwrite & hit_stat;

  assign sel = decode(paddr);

  // byte strobes make half-word writes touch only their lanes
  wire clr_stby = wr_ctl & pstrb[`PMSW_LANE_CTL] // R2
                  & pwdata[`PMSW_STBCLR_BIT]; // R18
  wire clr_wk = wr_ctl & pstrb[`PMSW_LANE_CTL]
                & pwdata[`PMSW_WUCLR_BIT]; // R18
  wire en_wr = wr_stat & pstrb[`PMSW_LANE_WPEN]; // R2
  wire clr_ldr = wr_stat & pstrb[`PMSW_LANE_LDR]
                 & (pwdata[`PMSW_LDR_HI:`PMSW_LDR_LO]
                    == `PMSW_LDR_ACTIVE); // R4

  // ************************************************************
  // wake events
  // ************************************************************
  wire en_rise = en_wr & pwdata[`PMSW_WPEN_BIT] & ~wake_en_ff;
  wire pin_rise = wake_s & ~wake_d_ff;
  wire pin_event = (wake_en_ff & pin_rise) // R8
                   | (en_rise & wake_s); // R10
  wire rtc_event = rtc_s & ~rtc_d_ff;
  wire wake_event = pin_event | rtc_event; // R15
  wire ldr_set = ldr_s & ~ldr_d_ff; // entry into low-driver sleep

  // ************************************************************
  // next values; a set always beats a clear in the same cycle
  // ************************************************************
  wire nxt_wake_en = en_wr ? pwdata[`PMSW_WPEN_BIT] : wake_en_ff;
  wire nxt_wuf = wake_event | (wuf_ff & ~clr_wk); // R15 R16
  wire nxt_standby_flag = stby_s | (standby_flag_ff & ~clr_stby); // R13 R14
  wire nxt_low_voltage_flag = stby_s ? low_voltage_flag_ff : lvd_s; // R11 R12
  wire nxt_wake_req = wake_en_ff & pin_rise & stby_s; // R8
  pmsw_pkg::pmsw_ldr_type nxt_ldr; // low-driver field next
  assign nxt_ldr = ldr_set ? `PMSW_LDR_ACTIVE // R3
                   : (clr_ldr ? `PMSW_LDR_NORMAL : ldr_ff); // R4

  // status word; ready bits read the synchronised sources and
  // ignore writes, reserved bits read zero
  pmsw_pkg::pmsw_word_type stat_word;
  assign stat_word = {12'h000, ldr_ff, // R3
                      hdsr_s, // R5
                      hdr_s, // R6
                      1'b0, vsr_s, // R7
                      5'h00, wake_en_ff, 5'h00,
                      low_voltage_flag_ff, // R11
                      standby_flag_ff, wuf_ff}; // R13 R15

  // read data chosen in the setup cycle, control reads as zero
  wire [31:0] nxt_rdata = (setup_ph & ~pwrite & hit_stat)
                          ? stat_word : `PMSW_RDATA_RST; // R18
  wire nxt_slverr = setup_ph & (sel == pmsw_pkg::pmsw_sel_none);

  // ************************************************************
  // edge history
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_d_ff <= 1'b0;
      rtc_d_ff <= 1'b0;
      ldr_d_ff <= 1'b0;
    end else begin
      wake_d_ff <= wake_s;
      rtc_d_ff <= rtc_s;
      ldr_d_ff <= ldr_s;
    end
  end

  // ************************************************************
  // status flags; rst clears them all, the clear strobes the standby and wakeup flags, a write of 11 the low-driver field, a standby wake none
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin // R1
      wake_en_ff <= 1'b0;
      wuf_ff <= 1'b0;
      standby_flag_ff <= 1'b0;
      low_voltage_flag_ff <= 1'b0;
      ldr_ff <= `PMSW_LDR_NORMAL;
      wake_req_ff <= 1'b0;
    end else begin
      wake_en_ff <= nxt_wake_en;
      wuf_ff <= nxt_wuf;
      standby_flag_ff <= nxt_standby_flag;
      low_voltage_flag_ff <= nxt_low_voltage_flag;
      ldr_ff <= nxt_ldr;
      wake_req_ff <= nxt_wake_req;
    end
  end

  // ************************************************************
  // bus answer registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= `PMSW_RDATA_RST;
      slverr_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // zero wait states: the answer was prepared in the setup cycle
  assign pready = 1'b1;
  assign prdata = rdata_ff;
  assign pslverr = slverr_ff & access_ph;
  assign wake_pin_pull_down = wake_en_ff; // R9
  assign standby_wake = wake_req_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_reset_zero;
    disable iff (1'b0)
    rst |=> (stat_word[19:0] == 20'h00000) && (prdata == 32'h0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // R1
    else $error("status not zero after reset");

  property p_ldr_code;
    (ldr_ff == 2'h0) || (ldr_ff == 2'h3);
  endproperty
  a_ldr_code: assert property (p_ldr_code) // R3
    else $error("low-driver field holds reserved code");

  property p_ldr_clear;
    clr_ldr && !ldr_set |=> ldr_ff == 2'h0;
  endproperty
  a_ldr_clear: assert property (p_ldr_clear) // R4
    else $error("low-driver field not cleared by 11");

  property p_pin_wake;
    $rose(wake_s) && wake_en_ff && stby_s |=> standby_wake
      ##1 !standby_wake;
  endproperty
  a_pin_wake: assert property (p_pin_wake) // R8
    else $error("standby wake pulse missing or long");

  // the pull-down may only move on an enable write, or after reset
  property p_pulldown;
    $changed(wake_pin_pull_down) |-> $past(rst)
      || ($past(en_wr)
          && (wake_pin_pull_down == $past(pwdata[`PMSW_WPEN_BIT])));
  endproperty
  a_pulldown: assert property (p_pulldown) // R9
    else $error("pull-down does not follow enable");

  property p_enable_high;
    en_rise && wake_s |=> wuf_ff;
  endproperty
  a_enable_high: assert property (p_enable_high) // R10
    else $error("enable with pin high gave no wakeup");

  property p_lvd_freeze;
    stby_s |=> $stable(low_voltage_flag_ff);
  endproperty
  a_lvd_freeze: assert property (p_lvd_freeze) // R12
    else $error("detector flag moved in standby");

  property p_standby_flag_hold;
    standby_flag_ff && !clr_stby |=> standby_flag_ff;
  endproperty
  a_standby_flag_hold: assert property (p_standby_flag_hold) // R14
    else $error("standby flag lost without clear");

  property p_wuf_set;
    $rose(rtc_s) |=> wuf_ff;
  endproperty
  a_wuf_set: assert property (p_wuf_set) // R15
    else $error("alarm did not set wakeup flag");

  property p_wuf_clear;
    wuf_ff && clr_wk && !wake_event |=> !wuf_ff;
  endproperty
  a_wuf_clear: assert property (p_wuf_clear) // R16
    else $error("wakeup flag not cleared by strobe");

  property p_ctl_reads_zero;
    setup_ph && !pwrite && hit_ctl |=> prdata == 32'h0;
  endproperty
  a_ctl_reads_zero: assert property (p_ctl_reads_zero) // R18
    else $error("control register read not zero");

  property p_ready_follow;
    setup_ph && !pwrite && hit_stat
      |=> (prdata[17] == $past(hdsr_s)) && (prdata[16] == $past(hdr_s));
  endproperty
  a_ready_follow: assert property (p_ready_follow) // R20
    else $error("ready flags not reported");

endmodule : pmsw_status

/* File: pmsw_regs.svh */
// register offsets, field positions, reset values and codes of the power status block
`ifndef PMSW_REGS_SVH
`define PMSW_REGS_SVH

// ************************************************************
// register offsets (byte addresses on the peripheral bus)
// ************************************************************
`define PMSW_CTL_OFS 12'h000
`define PMSW_STAT_OFS 12'h004

// ************************************************************
// reset values
// ************************************************************
`define PMSW_STAT_RST 32'h0000_0000
`define PMSW_RDATA_RST 32'h0000_0000

// ************************************************************
// control register write-one strobes
// ************************************************************
`define PMSW_STBCLR_BIT 3
`define PMSW_WUCLR_BIT 2

// ************************************************************
// status register fields
// ************************************************************
`define PMSW_LDR_HI 19
`define PMSW_LDR_LO 18
`define PMSW_HDSR_BIT 17
`define PMSW_HDR_BIT 16
`define PMSW_VSR_BIT 14
`define PMSW_WPEN_BIT 8
`define PMSW_LOW_VOLTAGE_FLAG_BIT 2
`define PMSW_STANDBY_FLAG_BIT 1
`define PMSW_WUF_BIT 0

// ************************************************************
// low-driver field codes
// ************************************************************
`define PMSW_LDR_ACTIVE 2'h3
`define PMSW_LDR_NORMAL 2'h0

// ************************************************************
// byte lanes holding writable fields
// ************************************************************
`define PMSW_LANE_CTL 0
`define PMSW_LANE_WPEN 1
`define PMSW_LANE_LDR 2

`endif

/* File: pmsw_pkg.sv */
// types shared by the power status block
package pmsw_pkg;

  // ************************************************************
  // register bus types
  // ************************************************************
  typedef logic [31:0] pmsw_word_type; // one bus data word
  typedef logic [1:0] pmsw_ldr_type; // low-driver ready field

  // address decode result
  typedef enum logic [1:0] {
    pmsw_sel_none,
    pmsw_sel_ctl,
    pmsw_sel_stat
  } pmsw_sel_type;

endpackage : pmsw_pkg

/* File: pmsw_sync.sv */
// two-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ps

module pmsw_sync #(
  parameter int WIDTH = 8 // number of levels carried
) (
  input wire logic mclk, // bus clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] d, // asynchronous levels
  output logic [WIDTH-1:0] q // levels in the mclk domain
);

  logic [WIDTH-1:0] meta_ff; // first stage, read only by q_ff
  logic [WIDTH-1:0] q_ff; // second stage

  // ************************************************************
  // two stages; each bit is its own level, no bus coherence is
  // promised, which is fine for independent status sources
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : pmsw_sync

/* File: pmsw_pin_model.sv */
// wake pin model: driven level, pull-down or a floating pin
`timescale 1ns/1ps

// **********
// far side of the wake pin
// **********
module pmsw_pin_model (
  input wire logic mclk, // bus clock
  input wire logic pull_down, // pull-down applied by the block
  input wire logic drive_en, // bench drives the pin
  input wire logic drive_lvl, // level while driven
  output logic wake_pin // level seen by the block
);
  logic last_ff = 1'b0; // last level on the pin

  // remember the level; a floating pin keeps no value, so it flips
  always_ff @(posedge mclk) begin
    if (drive_en) begin
      last_ff <= drive_lvl;
    end else if (!pull_down) begin
      last_ff <= ~last_ff;
    end else begin
      last_ff <= 1'b0;
    end
  end

  // released pin stays low only while the pull-down is on, otherwise it flips
  assign wake_pin = drive_en ? drive_lvl : (pull_down ? 1'b0 : ~last_ff);
endmodule : pmsw_pin_model

/* File: pmsw_status_tb_top.sv */
// self-checking bench for the power status block
`timescale 1ns/1ps
`include "pmsw_regs.svh"

// **********
// bench top
// **********
module pmsw_status_tb_top;
  localparam logic [11:0] ctl = `PMSW_CTL_OFS; // control register
  localparam logic [11:0] st = `PMSW_STAT_OFS; // status register
  localparam logic [31:0] f_wuf = 32'h1 << `PMSW_WUF_BIT; // wakeup
  localparam logic [31:0] f_standby_flag = 32'h1 << `PMSW_STANDBY_FLAG_BIT; // standby
  localparam logic [31:0] f_lvd = 32'h1 << `PMSW_LOW_VOLTAGE_FLAG_BIT; // detector
  localparam logic [31:0] f_wpen = 32'h1 << `PMSW_WPEN_BIT; // wake enable
  localparam logic [31:0] f_ldr = 32'h3 << `PMSW_LDR_LO; // low-driver
  logic mclk = 1'b0; // bus clock
  logic rst = 1'b1; // reset, held at start
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb enable
  logic pwrite = 1'b0; // apb direction
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [3:0] pstrb = 4'h0; // apb strobes
  logic [31:0] prdata; // apb read data
  logic pready; // apb ready
  logic pslverr; // apb error
  logic wake_drv_en = 1'b1; // bench drives the wake pin
  logic wake_lvl = 1'b0; // driven wake level
  logic wake_pin; // pin level from the model
  logic rtc_alarm = 1'b0; // alarm level
  logic standby_active = 1'b0; // standby level
  logic deep_sleep_low_driver = 1'b0; // low-driver sleep level
  logic [3:0] src = 4'h0; // switch, high-driver, vsel, detector
  logic wake_pin_pull_down; // pull-down from the block
  logic standby_wake; // wake request pulse
  pmsw_pkg::pmsw_word_type rdat; // last read data
  logic err; // last error response
  int pos[4] = '{`PMSW_HDSR_BIT, `PMSW_HDR_BIT, `PMSW_VSR_BIT,
    `PMSW_LOW_VOLTAGE_FLAG_BIT}; // bit of each source
  int miscompares = 0; // mismatches
  int comparisons = 0; // checks made
  int cycles = 0; // clock count for the hang guard
  int pulses; // wake pulses seen

  always #5 mclk = ~mclk;

  pmsw_status i_pmsw_status (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .rtc_alarm(rtc_alarm),
    .standby_active(standby_active),
    .deep_sleep_low_driver(deep_sleep_low_driver),
    .high_driver_switch_ready_in(src[0]), .high_driver_ready_in(src[1]),
    .regulator_voltage_select_ready_in(src[2]),
    .low_voltage_detector(src[3]),
    .wake_pin_pull_down(wake_pin_pull_down), .standby_wake(standby_wake));

  pmsw_pin_model i_pmsw_pin_model (.mclk(mclk),
    .pull_down(wake_pin_pull_down), .drive_en(wake_drv_en),
    .drive_lvl(wake_lvl), .wake_pin(wake_pin));

  // **********
  // tasks
  // **********
  // verdict and end of run
  task close_out;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // compare one value
  task chk(input pmsw_pkg::pmsw_word_type got,
    input pmsw_pkg::pmsw_word_type exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; answer taken in the cycle pready is high
  task apb(input logic wr, input logic [11:0] a,
    input pmsw_pkg::pmsw_word_type d, input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // the answer is taken at the edge that samples pready high
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input pmsw_pkg::pmsw_word_type d,
    input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask : wr

  task rd(input logic [11:0] a, input pmsw_pkg::pmsw_word_type exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdat, exp);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // hang guard, far above the roughly two hundred cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      $display("[ERR] %0t run timed out", $time);
      close_out;
    end
  end

  // **********
  // main sequence
  // **********
  initial begin
    cyc(16);
    rst <= 1'b0;
    rd(st, 32'h0);
    rd(ctl, 32'h0);
    // each ready source alone; writes of zero must not touch them;
    // software only polls the ready flags, never sets the switch
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      src <= 4'h1 << i;
      cyc(4);
      wr(st, 32'h0, 4'hf);
      rd(st, 32'h1 << pos[i]);
    end
    standby_active <= 1'b1;
    cyc(4);
    src <= 4'h0;
    cyc(4);
    rd(st, f_lvd | f_standby_flag);
    standby_active <= 1'b0;
    cyc(4);
    rd(st, f_standby_flag);
    wr(ctl, 32'h0, 4'hf);
    rd(st, f_standby_flag);
    wr(ctl, 32'h8, 4'h1);
    rd(st, 32'h0);
    rd(ctl, 32'h0);
    // wake pin in standby; floating pin held low by the pull-down
    wr(st, f_wpen, 4'h3);
    standby_active <= 1'b1;
    wake_drv_en <= 1'b0;
    cyc(4);
    rd(st, f_wpen | f_standby_flag);
    chk({31'h0, wake_pin_pull_down}, 32'h1);
    wake_drv_en <= 1'b1;
    wake_lvl <= 1'b1;
    pulses = 0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      pulses += (standby_wake === 1'b1);
    end
    chk(pulses, 32'h1);
    rd(st, f_wpen | f_standby_flag | f_wuf);
    standby_active <= 1'b0;
    cyc(3);
    wr(ctl, 32'hc, 4'h1);
    rd(st, f_wpen);
    // enable while the pin is already high
    wr(st, 32'h0, 4'h3);
    cyc(4);
    rd(st, 32'h0);
    chk({31'h0, wake_pin_pull_down}, 32'h0);
    wr(st, f_wpen, 4'h3);
    rd(st, f_wpen | f_wuf);
    wr(ctl, 32'h4, 4'h1);
    rd(st, f_wpen);
    wr(st, 32'h0, 4'h3);
    wake_lvl <= 1'b0;
    rtc_alarm <= 1'b1;
    cyc(4);
    rd(st, f_wuf);
    rtc_alarm <= 1'b0;
    wr(ctl, 32'h4, 4'h1);
    rd(st, 32'h0);
    // low-driver field: only 11 in lane 2 clears it
    deep_sleep_low_driver <= 1'b1;
    cyc(4);
    rd(st, f_ldr);
    wr(st, 32'h0008_0000, 4'hf);
    rd(st, f_ldr);
    wr(st, f_ldr, 4'h3);
    rd(st, f_ldr);
    wr(st, f_ldr, 4'hc);
    rd(st, 32'h0);
    deep_sleep_low_driver <= 1'b0;
    // unmapped places answer with an error and change nothing
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    chk(rdat, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(12'h00c, f_wpen, 4'hf);
    rd(st, 32'h0);
    // reset in mid-run wipes the sticky flags
    standby_active <= 1'b1;
    rtc_alarm <= 1'b1;
    cyc(4);
    standby_active <= 1'b0;
    rtc_alarm <= 1'b0;
    rd(st, f_standby_flag | f_wuf);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    rd(st, 32'h0);
    close_out;
  end
endmodule : pmsw_status_tb_top
